// file: core/ssc_spindle_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module ssc_spindle_ctrl
   import ssc_pkg::*;
#(
   parameter int unsigned STALL_TK  = STALL_TICKS,
   parameter int unsigned REFERENCE_CLOCK_IN_LIM  = REFERENCE_CLOCK_IN_LOST
) (
   input  wire logic          sys_clk,
   input  wire logic          nrst,
   input  wire logic          reference_clock_in,
   input  wire logic          hall_index_input,
   input  wire logic          hall_phase_input_b,
   input  wire logic          hall_phase_input_c,
   input  wire logic          start,
   input  wire logic          supply_low,
   output logic               hall_bias_output,
   output logic               phase_drive_a,
   output logic               phase_drive_b,
   output logic               phase_drive_c,
   output ssc_loop_type       loop_out,
   output logic               fault,
   output logic               at_speed_o,
   output logic               at_speed_oe_n
);
   localparam logic [CNT_W-1:0] STALL_C = CNT_W'(STALL_TK);
   localparam logic [CNT_W-1:0] NOM_C   = CNT_W'(NOM_TICKS);
   localparam logic [CNT_W-1:0] LOCK_LO = CNT_W'(LOCK_LO_TK);
   localparam logic [CNT_W-1:0] LOCK_HI = CNT_W'(LOCK_HI_TK);
   localparam logic [PRE_W-1:0] PRE_TOP = PRE_W'(TICK_DIV - 1);
   localparam logic [20:0]      REFERENCE_CLOCK_IN_C  = 21'(REFERENCE_CLOCK_IN_LIM);
   localparam logic signed [CNT_W:0]  PMAX = (CNT_W+1)'(2**(PROP_W-1) - 1);
   localparam logic signed [ACC_W-1:0] AMAX = ACC_W'(2**(ACC_W-1) - 1);
   localparam logic signed [ACC_W-1:0] AMIN = -AMAX;

   logic              rst_a_r, rst_n;
   logic [SYNC_W-1:0] sy1_r, sy2_r;
   logic              ref_d_r, idx_d_r;
   logic              ref_rise, idx_rise, hall_a, start_s, low_s;
   logic [PRE_W-1:0]  pre_r;
   logic              tick;
   logic [CNT_W-1:0]  cnt_r;
   logic              seen_r, stalled_r, timeout;
   logic [20:0]       reference_clock_in_cnt_r;
   logic              reference_clock_in_bad_r;
   logic signed [CNT_W:0] err;
   logic              over;
   logic signed [PROP_W-1:0] prop_nxt;
   logic signed [ACC_W-1:0]  acc_r;
   logic signed [ACC_W+1:0]  acc_sum;
   logic              locked_r;
   logic              drive_ok;
   logic [2:0]        phase_r;
   ssc_comm_type      comm;

   // Reset release through two stages
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rst_a_r <= 1'b0;
         rst_n   <= 1'b0;
      end else begin
         rst_a_r <= 1'b1;
         rst_n   <= rst_a_r;
      end
   end

   // Pins are asynchronous to sys_clk
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sy1_r <= '0;
         sy2_r <= '0;
      end else begin
         sy1_r <= {supply_low, start, hall_phase_input_c,
                   hall_phase_input_b, hall_index_input,
                   reference_clock_in};
         sy2_r <= sy1_r;
      end
   end

   assign ref_rise = sy2_r[0] & ~ref_d_r;
   assign hall_a   = sy2_r[1];
   assign idx_rise = hall_a & ~idx_d_r;
   assign start_s  = sy2_r[4];
   assign low_s    = sy2_r[5];

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_d_r <= 1'b0;
         idx_d_r <= 1'b0;
      end else begin
         ref_d_r <= sy2_r[0];
         idx_d_r <= hall_a;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         pre_r <= '0;
      else if (idx_rise)
         pre_r <= '0;
      else if (ref_rise)
         pre_r <= pre_r + 1'b1;
   end
   assign tick = ref_rise && pre_r == PRE_TOP;

   // preset on index; counter doubles as the timeout
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         cnt_r <= '0;
      else if (idx_rise)
         cnt_r <= '0;
      else if (tick && !timeout)
         cnt_r <= cnt_r + 1'b1;
   end
   assign timeout = cnt_r >= STALL_C;

   // stall held until a rising index
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         stalled_r <= 1'b0;
         seen_r    <= 1'b0;
      end else begin
         if (idx_rise)
            stalled_r <= 1'b0;
         else if (timeout)
            stalled_r <= 1'b1;
         if (idx_rise)
            seen_r <= 1'b1;
      end
   end

   // reference loss watchdog on the system clock
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reference_clock_in_cnt_r <= '0;
         reference_clock_in_bad_r <= 1'b0;
      end else if (ref_rise) begin
         reference_clock_in_cnt_r <= '0;
         reference_clock_in_bad_r <= 1'b0;
      end else if (reference_clock_in_cnt_r >= REFERENCE_CLOCK_IN_C) begin
         reference_clock_in_bad_r <= 1'b1;
      end else begin
         reference_clock_in_cnt_r <= reference_clock_in_cnt_r + 1'b1;
      end
   end

   // error against the nominal period of the divider
   assign err  = $signed({1'b0, cnt_r}) - $signed({1'b0, NOM_C});
   assign over = err > PMAX || err < -PMAX;
   always_comb begin
      if (err > PMAX)
         prop_nxt = PROP_W'(PMAX);
      else if (err < -PMAX)
         prop_nxt = -PROP_W'(PMAX);
      else
         prop_nxt = err[PROP_W-1:0];
   end

   // wide accumulator, clamped instead of wrapping
   assign acc_sum = (ACC_W+2)'(acc_r) + (ACC_W+2)'(err);

   // load prop, boost and accumulator on index after the first; integ follows acc_r every cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_r    <= '0;
         loop_out <= '0;
      end else begin
         loop_out.integ <= acc_r[ACC_W-1 -: INT_W];
         if (idx_rise && seen_r) begin
            loop_out.prop  <= prop_nxt;
            loop_out.boost <= over;
            if (acc_sum > (ACC_W+2)'(AMAX))
               acc_r <= AMAX;
            else if (acc_sum < (ACC_W+2)'(AMIN))
               acc_r <= AMIN;
            else
               acc_r <= acc_sum[ACC_W-1:0];
         end
      end
   end

   // lock window on the measured period
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         locked_r <= 1'b0;
      else if (stalled_r || timeout)
         locked_r <= 1'b0;
      else if (idx_rise && seen_r)
         locked_r <= cnt_r >= LOCK_LO && cnt_r <= LOCK_HI;
   end
   assign at_speed_o    = 1'b0;
   assign at_speed_oe_n = ~locked_r;

   // any fault source blocks the drives
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         fault <= 1'b0;
      else
         fault <= stalled_r | timeout | low_s | reference_clock_in_bad_r;
   end
   assign drive_ok = start_s & ~stalled_r & ~timeout & ~low_s & ~reference_clock_in_bad_r;
   assign comm     = ssc_comm_type'(sy2_r[3:1]);

   // six-step commutation, illegal codes leave every phase off
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_r <= '0;
      end else if (!drive_ok) begin
         phase_r <= '0;
      end else begin
         unique case (comm)
            SSC_C_1, SSC_C_3: phase_r <= 3'h1;
            SSC_C_2, SSC_C_6: phase_r <= 3'h2;
            SSC_C_4, SSC_C_5: phase_r <= 3'h4;
            default:          phase_r <= 3'h0;
         endcase
      end
   end
   assign {phase_drive_c, phase_drive_b, phase_drive_a} = phase_r;

   // Sensor bias follows the released reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         hall_bias_output <= 1'b0;
      else
         hall_bias_output <= 1'b1;
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence s_loaded;
      idx_rise && seen_r;
   endsequence

   AST_PRESET: assert property (idx_rise |=> cnt_r == '0)
      else $error("counter not preset by index");
   AST_PROP_LOAD: assert property ((s_loaded and !over) |=>
      loop_out.prop == $past(err[PROP_W-1:0]))
      else $error("proportional value not loaded");
   AST_INTEG: assert property (##1 loop_out.integ ==
      $past(acc_r[ACC_W-1 -: INT_W]))
      else $error("integral bits wrong");
   AST_CLAMP: assert property ((s_loaded and err > PMAX) |=>
      loop_out.prop == PROP_W'(PMAX))
      else $error("proportional not clamped high");
   AST_CLAMP_NEG: assert property ((s_loaded and err < -PMAX) |=>
      loop_out.prop == -PROP_W'(PMAX))
      else $error("proportional not clamped low");
   AST_BOOST: assert property (s_loaded |=>
      loop_out.boost == $past(over))
      else $error("boost mismatch");
   AST_ACC_SAT: assert property
      ((s_loaded and acc_sum < (ACC_W+2)'(AMIN)) |=> acc_r == AMIN)
      else $error("accumulator wrapped");
   AST_TIMEOUT: assert property (timeout && !idx_rise |=>
      stalled_r ##1 fault)
      else $error("timeout not flagged");
   AST_STALL_OFF: assert property (stalled_r |=>
      !phase_drive_a && !phase_drive_b && !phase_drive_c)
      else $error("drive during stall");
   AST_LOWV: assert property (low_s |=> fault && !phase_drive_a)
      else $error("low supply not handled");
   AST_REFERENCE_CLOCK_IN: assert property (reference_clock_in_bad_r |=> fault && !phase_drive_b)
      else $error("reference loss not handled");
   AST_LOCK: assert property ((s_loaded and !timeout && !stalled_r)
      |=> at_speed_oe_n !=
      ($past(cnt_r) >= LOCK_LO && $past(cnt_r) <= LOCK_HI))
      else $error("lock output wrong");
   AST_LOCK_STALL: assert property (stalled_r |=> at_speed_oe_n)
      else $error("lock kept during stall");
   AST_COMM: assert property (drive_ok && comm == SSC_C_3 |=>
      phase_drive_a && !phase_drive_c)
      else $error("commutation wrong");
endmodule : ssc_spindle_ctrl
`default_nettype wire

// file: core/ssc_pkg.sv
package ssc_pkg;
   // Reference rate and the speed divider of the loop
   localparam int unsigned REF_HZ      = 2_000_000;
   localparam int unsigned DIVIDE      = 33336;
   localparam int unsigned TICK_DIV    = 16;
   localparam int unsigned NOM_TICKS   = DIVIDE / TICK_DIV;
   // Lock window on the motor speed scale
   localparam int unsigned SPEED_NOM   = 3600;
   localparam int unsigned LOCK_SLOW   = 3585;
   localparam int unsigned LOCK_FAST   = 3615;
   localparam int unsigned LOCK_HI_TK  = NOM_TICKS * SPEED_NOM / LOCK_SLOW;
   localparam int unsigned LOCK_LO_TK  = NOM_TICKS * SPEED_NOM / LOCK_FAST;
   // Stalled rotor timeout, midway in 0.850 to 0.900 s, in milliseconds
   localparam int unsigned STALL_MS    = 875;
   localparam int unsigned STALL_TICKS = REF_HZ / 1000 * STALL_MS / TICK_DIV;
   // Slowest reference that keeps the drivers on
   localparam int unsigned SYS_HZ      = 125_000_000;
   localparam int unsigned REFERENCE_CLOCK_IN_MIN_HZ = 100;
   localparam int unsigned REFERENCE_CLOCK_IN_LOST   = SYS_HZ / REFERENCE_CLOCK_IN_MIN_HZ;
   // Widths of counter, channels and accumulator
   localparam int unsigned CNT_W       = 17;
   localparam int unsigned PRE_W       = 4;
   localparam int unsigned PROP_W      = 8;
   localparam int unsigned ACC_W       = 16;
   localparam int unsigned INT_W       = 8;
   localparam int unsigned SYNC_W      = 6;

   typedef enum logic [2:0] {
      SSC_C_BAD0 = 3'h0,
      SSC_C_1    = 3'h1,
      SSC_C_2    = 3'h2,
      SSC_C_3    = 3'h3,
      SSC_C_4    = 3'h4,
      SSC_C_5    = 3'h5,
      SSC_C_6    = 3'h6,
      SSC_C_BAD7 = 3'h7
   } ssc_comm_type;

   typedef struct packed {
      logic signed [PROP_W-1:0] prop;
      logic        [INT_W-1:0]  integ;
      logic                     boost;
   } ssc_loop_type;
endpackage : ssc_pkg

// file: dv/ssc_motor_model.sv
`timescale 1ns/100ps
`default_nettype none
module ssc_motor_model (
   input  wire logic       hall_bias_output,
   input  wire logic [2:0] hall_code,
   input  wire logic       ref_run,
   output logic            reference_clock_in,
   output logic            hall_index_input,
   output logic            hall_phase_input_b,
   output logic            hall_phase_input_c
);
   logic ref_r;

   // Edges land on multiples of 32 ns, away from the sampling edge
   initial begin
      ref_r = 1'b0;
      forever begin
         #32;
         ref_r = ref_run ? ~ref_r : 1'b0;
      end
   end

   assign reference_clock_in = ref_r;
   // Switches are powered from the bias pin; unpowered they read low
   assign {hall_phase_input_c, hall_phase_input_b, hall_index_input} =
      hall_bias_output ? hall_code : 3'h0;
endmodule : ssc_motor_model
`default_nettype wire

// file: dv/ssc_spindle_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ssc_spindle_ctrl_tb
   import ssc_pkg::*;
;
   localparam int TK = 128;
   logic         sys_clk;
   logic         nrst;
   logic         start;
   logic         supply_low;
   logic [2:0]   hall_code;
   logic         ref_run;
   logic         ref_in;
   logic         h_a;
   logic         h_b;
   logic         h_c;
   logic         bias;
   logic         pa;
   logic         pb;
   logic         pc;
   ssc_loop_type loop_out;
   logic         fault;
   logic         lock_o;
   logic         lock_oe_n;
   logic [3:0]   fd;
   int           fail_count;
   int           checks_done;
   logic [2:0]   comm_exp [8] = '{3'h0, 3'h1, 3'h2, 3'h1,
                                  3'h4, 3'h4, 3'h2, 3'h0};

   assign fd = {fault, pc, pb, pa};

   ssc_spindle_ctrl #(.STALL_TK(200), .REFERENCE_CLOCK_IN_LIM(500)) DUT (
      .sys_clk(sys_clk), .nrst(nrst), .reference_clock_in(ref_in),
      .hall_index_input(h_a), .hall_phase_input_b(h_b),
      .hall_phase_input_c(h_c), .start(start), .supply_low(supply_low),
      .hall_bias_output(bias), .phase_drive_a(pa), .phase_drive_b(pb),
      .phase_drive_c(pc), .loop_out(loop_out), .fault(fault),
      .at_speed_o(lock_o), .at_speed_oe_n(lock_oe_n));

   ssc_motor_model u_motor (
      .hall_bias_output(bias), .hall_code(hall_code), .ref_run(ref_run),
      .reference_clock_in(ref_in), .hall_index_input(h_a),
      .hall_phase_input_b(h_b), .hall_phase_input_c(h_c));

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : cyc

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run

   task automatic test_reset();
      cyc(20);
      check({fd, lock_o, lock_oe_n, bias}, 7'h02);
      nrst = 1'b1;
      cyc(4);
      check(bias, 1'b1);
      $display("reset test done");
   endtask : test_reset

   task automatic test_comm();
      for (int i = 0; i < 8; i++) begin
         hall_code = 3'(i);
         cyc(8);
         check(fd, {1'b0, comm_exp[i]});
      end
      hall_code = 3'h1;
      cyc(8);
      $display("commutation test done");
   endtask : test_comm

   task automatic test_faults();
      start = 1'b0;
      cyc(8);
      check(fd[2:0], 3'h0);
      start = 1'b1;
      supply_low = 1'b1;
      cyc(8);
      check(fd, 4'h8);
      supply_low = 1'b0;
      cyc(8);
      check(fd, 4'h1);
      ref_run = 1'b0;
      cyc(450);
      check(fd, 4'h1);
      cyc(70);
      check(fd, 4'h8);
      ref_run = 1'b1;
      cyc(100);
      check(fd, 4'h1);
      $display("fault test done");
   endtask : test_faults

   task automatic index_pulse();
      hall_code = 3'h0;
      cyc(8);
      hall_code = 3'h1;
   endtask : index_pulse

   task automatic test_loop();
      index_pulse();
      cyc(12 * TK);
      index_pulse();
      cyc(8);
      check($unsigned(loop_out.prop), 8'h81);
      check(loop_out.boost, 1'b1);
      check(loop_out.integ[7], 1'b1);
      cyc(TK);
      check($unsigned(loop_out.prop), 8'h81);
      // Short periods pile up until the accumulator must saturate
      repeat (14) begin
         index_pulse();
         cyc(8);
      end
      check(loop_out.integ, 8'h80);
      $display("loop test done");
   endtask : test_loop

   task automatic test_stall();
      index_pulse();
      cyc(180 * TK);
      check(fd, 4'h1);
      cyc(40 * TK);
      check(fd, 4'h8);
      check({lock_o, lock_oe_n}, 2'b01);
      index_pulse();
      cyc(10);
      check(fd, 4'h1);
      $display("stall test done");
   endtask : test_stall

   initial begin
      fail_count = 0;
      checks_done = 0;
      nrst = 1'b0;
      start = 1'b1;
      supply_low = 1'b0;
      hall_code = 3'h0;
      ref_run = 1'b1;
      test_reset();
      test_comm();
      test_faults();
      test_loop();
      test_stall();
      complete_run();
   end

   // Longest path is the stall wait, roughly 31k cycles in all
   initial begin
      repeat (60000) @(posedge sys_clk);
      fail_count++;
      complete_run();
   end
endmodule : ssc_spindle_ctrl_tb
`default_nettype wire
